// File: rtl/multi_channel_timer_pkg.sv
// constants and types of the multi-channel timer control block
package multi_channel_timer_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SYNC   = 8'h61;
   localparam logic [7:0] IDX_MODE   = 8'h62;
   localparam logic [7:0] IDX_PAIR   = 8'h63;
   localparam logic [7:0] IDX_CTRL0  = 8'h64;
   localparam logic [7:0] IDX_IOCTL0 = 8'h65;
   localparam logic [7:0] IDX_COUNT  = 8'h66;
   localparam logic [7:0] IDX_GRA    = 8'h68;
   localparam logic [7:0] IDX_GRB    = 8'h6A;

   localparam logic [9:0] ADDR_SYNC   = {IDX_SYNC, 2'b00};
   localparam logic [9:0] ADDR_MODE   = {IDX_MODE, 2'b00};
   localparam logic [9:0] ADDR_PAIR   = {IDX_PAIR, 2'b00};
   localparam logic [9:0] ADDR_CTRL0  = {IDX_CTRL0, 2'b00};
   localparam logic [9:0] ADDR_IOCTL0 = {IDX_IOCTL0, 2'b00};
   localparam logic [9:0] ADDR_COUNT  = {IDX_COUNT, 2'b00};
   localparam logic [9:0] ADDR_GRA    = {IDX_GRA, 2'b00};
   localparam logic [9:0] ADDR_GRB    = {IDX_GRB, 2'b00};

   // values after reset
   localparam logic [7:0] RST_SYNC   = 8'h00;
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [7:0] RST_PAIR   = 8'h00;
   localparam logic [7:0] RST_CTRL0  = 8'h80;
   localparam logic [7:0] RST_IOCTL0 = 8'h88;

   // writable bits; the rest hold their reset value
   localparam logic [7:0] MASK_SYNC   = 8'h1F;
   localparam logic [7:0] MASK_MODE   = 8'h40;
   localparam logic [7:0] MASK_PAIR   = 8'h30;
   localparam logic [7:0] MASK_CTRL0  = 8'h7F;
   localparam logic [7:0] MASK_IOCTL0 = 8'h77;

   // field positions
   localparam int CLK_SEL_LSB    = 0;
   localparam int EDGE_SEL_LSB   = 3;
   localparam int CLR_SEL_LSB    = 5;
   localparam int PAIR_CMD_LSB   = 4;
   localparam int PHASE_FLAG_BIT = 6;
   localparam int SYNC_CH0_BIT   = 0;
   localparam int IO_A_LSB       = 0;
   localparam int IO_B_LSB       = 4;

   typedef enum logic [1:0] {
      CLR_NONE = 2'b00,
      CLR_GRA  = 2'b01,
      CLR_GRB  = 2'b10,
      CLR_SYNC = 2'b11
   } clear_src_t;

   typedef enum logic [1:0] {
      EDGE_RISE  = 2'b00,
      EDGE_FALL  = 2'b01,
      EDGE_BOTH0 = 2'b10,
      EDGE_BOTH1 = 2'b11
   } edge_sel_t;

   typedef enum logic [1:0] {
      PAIR_INDEP0   = 2'b00,
      PAIR_INDEP1   = 2'b01,
      PAIR_COMPL    = 2'b10,
      PAIR_RESET_SY = 2'b11
   } pair_mode_t;

endpackage : multi_channel_timer_pkg

// File: rtl/count_tick_if.sv
// carrier between the control block and its count tick generator
`timescale 1ns/100ps
`default_nettype none
interface count_tick_if;
   logic [2:0] clk_sel;
   logic [1:0] edge_sel;
   logic       tick;

   modport ctrl (output clk_sel, output edge_sel, input tick);
   modport gen  (input clk_sel, input edge_sel, output tick);
endinterface : count_tick_if
`default_nettype wire

// File: rtl/count_tick_gen.sv
// prescaler and external clock edge selection for one counter
`timescale 1ns/100ps
`default_nettype none
module count_tick_gen (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // external count inputs a to d
   input  wire logic [3:0] ext_count_in,
   // selection and tick
   count_tick_if.gen       sel
);

   logic [2:0] div_q;
   logic [3:0] ext_prev_q;
   logic       ext_now;
   logic       ext_prev;
   logic       rise;
   logic       fall;

   // free-running divider for the internal rates
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_q <= 4'h0;
      end else begin
         ext_prev_q <= ext_count_in;
      end
   end

   always_comb begin
      ext_now  = ext_count_in[sel.clk_sel[1:0]];   // [R2]
      ext_prev = ext_prev_q[sel.clk_sel[1:0]];
      rise     = ext_now & ~ext_prev;
      fall     = ~ext_now & ext_prev;
      sel.tick = 1'b0;
      if (sel.clk_sel[2]) begin
         unique case (sel.edge_sel)   // [R3]
            2'b00:   sel.tick = rise;
            2'b01:   sel.tick = fall;
            default: sel.tick = rise | fall;
         endcase
      end else begin
         unique case (sel.clk_sel[1:0])   // [R1]
            2'b00: sel.tick = 1'b1;
            2'b01: sel.tick = div_q[0];
            2'b10: sel.tick = &div_q[1:0];
            2'b11: sel.tick = &div_q;
         endcase
      end
   end

endmodule : count_tick_gen
`default_nettype wire

// File: rtl/multi_channel_timer.sv
// channel 0 counter control and unit-wide timer settings over apb
//
// Operation
// R1: source 000..011 counts internal clock divided by 1, 2, 4, 8.
// R2: source top bit set counts external input a, b, c or d.
// R3: edge field: 00 rising, 01 falling, 1x both edges.
// R4: clear code 00 never clears; 01 clears on gra match or capture.
// R5: clear code 10 clears on grb match or grb capture.
// R6: clear code 11 clears with other synchronized counters' clear.
// R7: pair field 00/01 independent, 10 complementary pwm for ch 3, 4.
// R8: pair field 11 runs channels 3, 4 in reset-synchronized pwm.
// R9: phase flag set puts channel 2 into phase counting mode.
// R10: gra in capture mode latches the count on the chosen edge.
// R11: count increments per selected edge; auto clear beats increment.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module multi_channel_timer #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // external count and capture inputs
   input  wire logic [3:0]       ext_count_in,
   input  wire logic             capture_in_a,
   input  wire logic             capture_in_b,
   // synchronous clear between channels
   input  wire logic             sync_clear_in,
   output logic                  sync_clear_out,
   // mode outputs to the other channels
   output logic      [4:0]       sync_enable,
   output logic                  ch2_phase_mode,
   output logic                  ch34_complementary,
   output logic                  ch34_reset_sync,
   output logic      [CNT_W-1:0] count_value
);

   logic [7:0]       sync_q;
   logic [7:0]       mode_q;
   logic [7:0]       pair_q;
   logic [7:0]       ctrl0_q;
   logic [7:0]       ioctl0_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] gra_q;
   logic [CNT_W-1:0] grb_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic             sync_clear_out_q;
   logic [4:0]       sync_enable_q;
   logic             ch2_phase_q;
   logic             ch34_compl_q;
   logic             ch34_rsync_q;
   logic             cap_a_prev_q;
   logic             cap_b_prev_q;

   logic             wr_en;
   logic             mapped;
   logic [31:0]      rd_word;
   logic [2:0]       ioa;
   logic [2:0]       iob;
   logic             cap_a;
   logic             cap_b;
   logic             match_a;
   logic             match_b;
   logic             clear_now;
   logic             tick;
   multi_channel_timer_pkg::clear_src_t clr_sel;

   count_tick_if tick_bus ();

   count_tick_gen u_tick (
      .pclk         (pclk),
      .presetn      (presetn),
      .ext_count_in (ext_count_in),
      .sel          (tick_bus.gen)
   );

   assign tick_bus.clk_sel  = ctrl0_q[multi_channel_timer_pkg::CLK_SEL_LSB +: 3];
   assign tick_bus.edge_sel = ctrl0_q[multi_channel_timer_pkg::EDGE_SEL_LSB +: 2];
   assign tick              = tick_bus.tick;

   // apb write strobe in the access cycle
   assign wr_en = psel & penable & pwrite & pready_q;

   // read decode
   always_comb begin
      mapped  = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (paddr[11:2])
         {2'b00, multi_channel_timer_pkg::IDX_SYNC}:
            rd_word = {24'h00_0000, sync_q};
         {2'b00, multi_channel_timer_pkg::IDX_MODE}:
            rd_word = {24'h00_0000, mode_q};
         {2'b00, multi_channel_timer_pkg::IDX_PAIR}:
            rd_word = {24'h00_0000, pair_q};
         {2'b00, multi_channel_timer_pkg::IDX_CTRL0}:
            rd_word = {24'h00_0000, ctrl0_q};
         {2'b00, multi_channel_timer_pkg::IDX_IOCTL0}:
            rd_word = {24'h00_0000, ioctl0_q};
         {2'b00, multi_channel_timer_pkg::IDX_COUNT}:
            rd_word = 32'(count_q);
         {2'b00, multi_channel_timer_pkg::IDX_GRA}:
            rd_word = 32'(gra_q);
         {2'b00, multi_channel_timer_pkg::IDX_GRB}:
            rd_word = 32'(grb_q);
         default: mapped = 1'b0;
      endcase
   end

   // apb answer: one wait-free access cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready_q  <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // unit-wide and channel 0 byte registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q   <= multi_channel_timer_pkg::RST_SYNC;
         mode_q   <= multi_channel_timer_pkg::RST_MODE;
         pair_q   <= multi_channel_timer_pkg::RST_PAIR;
         ctrl0_q  <= multi_channel_timer_pkg::RST_CTRL0;
         ioctl0_q <= multi_channel_timer_pkg::RST_IOCTL0;
      end else if (wr_en && mapped && pstrb[0]) begin
         unique case (paddr[11:2])
            {2'b00, multi_channel_timer_pkg::IDX_SYNC}:
               sync_q <= (pwdata[7:0] & multi_channel_timer_pkg::MASK_SYNC) |
                  (multi_channel_timer_pkg::RST_SYNC &
                   ~multi_channel_timer_pkg::MASK_SYNC);
            {2'b00, multi_channel_timer_pkg::IDX_MODE}:
               mode_q <= (pwdata[7:0] & multi_channel_timer_pkg::MASK_MODE) |
                  (multi_channel_timer_pkg::RST_MODE &
                   ~multi_channel_timer_pkg::MASK_MODE);
            {2'b00, multi_channel_timer_pkg::IDX_PAIR}:
               pair_q <= (pwdata[7:0] & multi_channel_timer_pkg::MASK_PAIR) |
                  (multi_channel_timer_pkg::RST_PAIR &
                   ~multi_channel_timer_pkg::MASK_PAIR);
            {2'b00, multi_channel_timer_pkg::IDX_CTRL0}:
               ctrl0_q <= (pwdata[7:0] & multi_channel_timer_pkg::MASK_CTRL0) |
                  (multi_channel_timer_pkg::RST_CTRL0 &
                   ~multi_channel_timer_pkg::MASK_CTRL0);
            {2'b00, multi_channel_timer_pkg::IDX_IOCTL0}:
               ioctl0_q <= (pwdata[7:0] &
                  multi_channel_timer_pkg::MASK_IOCTL0) |
                  (multi_channel_timer_pkg::RST_IOCTL0 &
                   ~multi_channel_timer_pkg::MASK_IOCTL0);
            default: ;
         endcase
      end
   end

   // capture and compare events
   assign ioa     = ioctl0_q[multi_channel_timer_pkg::IO_A_LSB +: 3];
   assign iob     = ioctl0_q[multi_channel_timer_pkg::IO_B_LSB +: 3];
   assign clr_sel = multi_channel_timer_pkg::clear_src_t'(
                       ctrl0_q[multi_channel_timer_pkg::CLR_SEL_LSB +: 2]);

   always_comb begin
      cap_a = 1'b0;
      cap_b = 1'b0;
      if (ioa[2]) begin
         unique case (ioa[1:0])   // [R10]
            2'b00:   cap_a = capture_in_a & ~cap_a_prev_q;
            2'b01:   cap_a = ~capture_in_a & cap_a_prev_q;
            default: cap_a = capture_in_a ^ cap_a_prev_q;
         endcase
      end
      if (iob[2]) begin
         unique case (iob[1:0])
            2'b00:   cap_b = capture_in_b & ~cap_b_prev_q;
            2'b01:   cap_b = ~capture_in_b & cap_b_prev_q;
            default: cap_b = capture_in_b ^ cap_b_prev_q;
         endcase
      end
   end

   assign match_a = tick & ~ioa[2] & (count_q == gra_q);
   assign match_b = tick & ~iob[2] & (count_q == grb_q);

   // automatic clear source
   always_comb begin
      unique case (clr_sel)
         multi_channel_timer_pkg::CLR_NONE: clear_now = 1'b0;   // [R4]
         multi_channel_timer_pkg::CLR_GRA:  clear_now = match_a | cap_a; // [R4]
         multi_channel_timer_pkg::CLR_GRB:  clear_now = match_b | cap_b; // [R5]
         multi_channel_timer_pkg::CLR_SYNC:
            clear_now = sync_clear_in &
                        sync_q[multi_channel_timer_pkg::SYNC_CH0_BIT]; // [R6]
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_a_prev_q <= 1'b0;
         cap_b_prev_q <= 1'b0;
      end else begin
         cap_a_prev_q <= capture_in_a;
         cap_b_prev_q <= capture_in_b;
      end
   end

   // counter: clear, then software load, then increment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= '0;
      end else if (clear_now) begin
         count_q <= '0;   // [R11] [R4] [R5] [R6]
      end else if (wr_en && paddr[11:2] ==
                   {2'b00, multi_channel_timer_pkg::IDX_COUNT}) begin
         count_q <= pwdata[CNT_W-1:0];
      end else if (tick) begin
         count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};   // [R11]
      end
   end

   // general registers: capture or software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gra_q <= '1;
         grb_q <= '1;
      end else begin
         if (cap_a) begin
            gra_q <= count_q;   // [R10]
         end else if (wr_en && paddr[11:2] ==
                      {2'b00, multi_channel_timer_pkg::IDX_GRA}) begin
            gra_q <= pwdata[CNT_W-1:0];
         end
         if (cap_b) begin
            grb_q <= count_q;   // [R5]
         end else if (wr_en && paddr[11:2] ==
                      {2'b00, multi_channel_timer_pkg::IDX_GRB}) begin
            grb_q <= pwdata[CNT_W-1:0];
         end
      end
   end

   // mode outputs and clear broadcast
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_clear_out_q <= 1'b0;
         sync_enable_q    <= 5'h00;
         ch2_phase_q      <= 1'b0;
         ch34_compl_q     <= 1'b0;
         ch34_rsync_q     <= 1'b0;
      end else begin
         sync_clear_out_q <= clear_now &
            (clr_sel != multi_channel_timer_pkg::CLR_SYNC) &
            sync_q[multi_channel_timer_pkg::SYNC_CH0_BIT];   // [R6]
         sync_enable_q    <= sync_q[4:0];
         ch2_phase_q      <=
            mode_q[multi_channel_timer_pkg::PHASE_FLAG_BIT];   // [R9]
         ch34_compl_q     <=
            pair_q[multi_channel_timer_pkg::PAIR_CMD_LSB +: 2] ==
            multi_channel_timer_pkg::PAIR_COMPL;   // [R7]
         ch34_rsync_q     <=
            pair_q[multi_channel_timer_pkg::PAIR_CMD_LSB +: 2] ==
            multi_channel_timer_pkg::PAIR_RESET_SY;   // [R8]
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign sync_clear_out     = sync_clear_out_q;
   assign sync_enable        = sync_enable_q;
   assign ch2_phase_mode     = ch2_phase_q;
   assign ch34_complementary = ch34_compl_q;
   assign ch34_reset_sync    = ch34_rsync_q;
   assign count_value        = count_q;

   // checks
   chk_div1_rate: assert property (   // [R1]
      @(posedge pclk) disable iff (!presetn)
      tick_bus.clk_sel == 3'b000 |-> tick)
      else $error("divide-by-1 source missed a tick");

   chk_div8_rate: assert property (   // [R1]
      @(posedge pclk)
      disable iff (!presetn || tick_bus.clk_sel != 3'b011)
      tick |=> !tick [*7] ##1 tick)
      else $error("divide-by-8 tick spacing wrong");

   chk_ext_rise: assert property (   // [R2] [R3]
      @(posedge pclk) disable iff (!presetn)
      (tick_bus.clk_sel == 3'b100 && tick_bus.edge_sel == 2'b00 &&
       $rose(ext_count_in[0])) |-> tick)
      else $error("rising edge of input a not counted");

   chk_ext_fall_only: assert property (   // [R3]
      @(posedge pclk) disable iff (!presetn)
      (tick_bus.clk_sel == 3'b101 && tick_bus.edge_sel == 2'b01 &&
       $stable(tick_bus.clk_sel) && !$fell(ext_count_in[1])) |-> !tick)
      else $error("tick without falling edge of input b");

   chk_gra_clear: assert property (   // [R4]
      @(posedge pclk) disable iff (!presetn)
      (clr_sel == multi_channel_timer_pkg::CLR_GRA && !ioa[2] && tick &&
       count_q == gra_q) |=> count_q == '0)
      else $error("count not cleared on gra match");

   chk_no_clear: assert property (   // [R4] [R11]
      @(posedge pclk) disable iff (!presetn)
      (clr_sel == multi_channel_timer_pkg::CLR_NONE && tick && !wr_en)
      |=> count_q == $past(count_q) + {{(CNT_W-1){1'b0}}, 1'b1})
      else $error("count did not step by one");

   chk_grb_capture: assert property (   // [R5]
      @(posedge pclk) disable iff (!presetn)
      (clr_sel == multi_channel_timer_pkg::CLR_GRB && cap_b)
      |=> count_q == '0 && grb_q == $past(count_q))
      else $error("grb capture did not clear count");

   chk_sync_clear: assert property (   // [R6]
      @(posedge pclk) disable iff (!presetn)
      (clr_sel == multi_channel_timer_pkg::CLR_SYNC && sync_clear_in &&
       sync_q[0]) |=> count_q == '0)
      else $error("synchronous clear ignored");

   chk_pair_mode: assert property (   // [R7] [R8]
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ch34_complementary == ($past(pair_q[5:4]) == 2'b10) &&
               ch34_reset_sync == ($past(pair_q[5:4]) == 2'b11))
      else $error("pair mode outputs wrong");

   chk_phase_flag: assert property (   // [R9]
      @(posedge pclk) disable iff (!presetn)
      $rose(mode_q[6]) |=> ch2_phase_mode)
      else $error("phase counting mode not entered");

   chk_gra_capture: assert property (   // [R10]
      @(posedge pclk) disable iff (!presetn)
      (ioa == 3'b100 && $rose(capture_in_a)) |=> gra_q == $past(count_q))
      else $error("gra did not latch count");

   chk_clear_priority: assert property (   // [R11]
      @(posedge pclk) disable iff (!presetn)
      (clear_now && tick) |=> count_q == '0)
      else $error("increment beat the clear");

   chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("apb access not answered at once");

endmodule : multi_channel_timer
`default_nettype wire

// File: bench/ext_pins_model.sv
// far side model: external count, capture and sync clear pins
`timescale 1ns/100ps
`default_nettype none
module ext_pins_model (
   // clock
   input  wire logic       pclk,
   // pins toward the timer
   output logic      [3:0] ext_count_in,
   output logic            capture_in_a,
   output logic            capture_in_b,
   output logic            sync_clear_in
);
   logic [6:0] pins_q = 7'h00;

   assign ext_count_in  = pins_q[3:0];
   assign capture_in_a  = pins_q[4];
   assign capture_in_b  = pins_q[5];
   assign sync_clear_in = pins_q[6];

   // one rise and one fall on pin w, two cycles apart
   task pulse(input int w);
      pins_q[w] <= 1'b1;
      repeat (2) @(posedge pclk);
      pins_q[w] <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : pulse
endmodule : ext_pins_model
`default_nettype wire

// File: bench/multi_channel_timer_tb.sv
// self-checking testbench of the timer control block
`timescale 1ns/100ps
`default_nettype none
module multi_channel_timer_tb;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  ext_in;
   logic        cap_a;
   logic        cap_b;
   logic        sclr_in;
   logic        sclr_out;
   int          n_clr;
   logic [4:0]  sync_en;
   logic        ph_mode;
   logic        compl;
   logic        rsync;
   logic [15:0] cnt;
   logic [31:0] rd;
   logic        slverr_seen;
   logic [15:0] c0;
   logic [15:0] dlt;
   logic [15:0] mx;
   logic [15:0] exp_c;
   int          err_count = 0;
   int          n_tests   = 0;

   always #20 pclk = ~pclk;

   multi_channel_timer #(.CNT_W(16)) multi_channel_timer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_in(ext_in), .capture_in_a(cap_a), .capture_in_b(cap_b),
      .sync_clear_in(sclr_in), .sync_clear_out(sclr_out),
      .sync_enable(sync_en),
      .ch2_phase_mode(ph_mode), .ch34_complementary(compl),
      .ch34_reset_sync(rsync), .count_value(cnt));

   ext_pins_model ext_pins_model_inst (
      .pclk(pclk), .ext_count_in(ext_in), .capture_in_a(cap_a),
      .capture_in_b(cap_b), .sync_clear_in(sclr_in));

   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // one apb transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      slverr_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, i, d);
   endtask : wr

   task automatic rchk(input logic [7:0] i, input logic [31:0] e);
      apb(1'b0, i, 32'h0);
      chk(rd, e);
   endtask : rchk

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_of_test;
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(multi_channel_timer_pkg::IDX_CTRL0, 32'h80);
      // internal prescaler: 8 ticks per 8*N cycles
      for (int k = 0; k < 4; k++) begin
         wr(multi_channel_timer_pkg::IDX_CTRL0, k);
         cyc(2);
         c0 = cnt;
         cyc(8 << k);
         dlt = cnt - c0;
         chk({16'h0000, dlt}, 32'h8);
      end
      // external inputs, each edge mode; other pin must not count
      for (int s = 0; s < 4; s++) begin
         for (int e = 0; e < 3; e++) begin
            wr(multi_channel_timer_pkg::IDX_CTRL0, {e[1:0], 1'b1, s[1:0]});
            c0 = cnt;
            ext_pins_model_inst.pulse((s + 1) % 4);
            ext_pins_model_inst.pulse(s);
            cyc(2);
            dlt = cnt - c0;
            chk({16'h0000, dlt}, (e == 2) ? 32'h2 : 32'h1);
         end
      end
      // capture on rising edge with clear codes 00, 01 and 10, no ticks
      wr(multi_channel_timer_pkg::IDX_IOCTL0, 32'h44);
      for (int k = 0; k < 3; k++) begin
         wr(multi_channel_timer_pkg::IDX_CTRL0, {k[1:0], 5'b00100});
         wr(multi_channel_timer_pkg::IDX_COUNT, 32'h1234);
         ext_pins_model_inst.pulse(4);
         rchk(multi_channel_timer_pkg::IDX_GRA, 32'h1234);
         exp_c = (k == 1) ? 16'h0000 : 16'h1234;
         chk(cnt, exp_c);
         ext_pins_model_inst.pulse(5);
         rchk(multi_channel_timer_pkg::IDX_GRB, exp_c);
         chk(cnt, (k == 2) ? 32'h0 : exp_c);
      end
      // synchronous clear only while channel 0 is synchronized
      for (int k = 0; k < 2; k++) begin
         wr(multi_channel_timer_pkg::IDX_SYNC, {31'h0, k == 0});
         wr(multi_channel_timer_pkg::IDX_CTRL0, 32'h64);
         wr(multi_channel_timer_pkg::IDX_COUNT, 32'h1234);
         chk(sync_en, {31'h0, k == 0});
         ext_pins_model_inst.pulse(6);
         chk(cnt, (k == 1) ? 32'h1234 : 32'h0);
      end
      // compare match clear wins over increment; clears are broadcast
      wr(multi_channel_timer_pkg::IDX_SYNC, 32'h1);
      wr(multi_channel_timer_pkg::IDX_IOCTL0, 32'h00);
      wr(multi_channel_timer_pkg::IDX_GRA, 32'h5);
      wr(multi_channel_timer_pkg::IDX_COUNT, 32'h0);
      wr(multi_channel_timer_pkg::IDX_CTRL0, 32'h20);
      mx = 16'h0000;
      n_clr = 0;
      repeat (40) begin
         @(posedge pclk);
         if (cnt > mx)
            mx = cnt;
         if (sclr_out === 1'b1)
            n_clr++;
      end
      chk(mx, 32'h5);
      chk(n_clr, 32'h6);
      // channel 3 and 4 pairing, phase counting flag
      for (int k = 0; k < 4; k++) begin
         wr(multi_channel_timer_pkg::IDX_PAIR, {k[1:0], 4'h0});
         cyc(2);
         chk({compl, rsync}, {k == 2, k == 3});
      end
      wr(multi_channel_timer_pkg::IDX_PAIR, 32'hFF);
      rchk(multi_channel_timer_pkg::IDX_PAIR, 32'h30);
      wr(multi_channel_timer_pkg::IDX_MODE, 32'hFF);
      rchk(multi_channel_timer_pkg::IDX_MODE, 32'h40);
      chk(ph_mode, 32'h1);
      wr(multi_channel_timer_pkg::IDX_MODE, 32'h00);
      cyc(2);
      chk(ph_mode, 32'h0);
      // unmapped address
      apb(1'b0, 8'h70, 32'h0);
      chk(slverr_seen, 32'h1);
      chk(rd, 32'h0);
      end_of_test;
   end
endmodule : multi_channel_timer_tb
`default_nettype wire
